// >>> ors_pkg.sv
/*
 package of constants for the over-range status and clock-out block.
 assumes one 25 MHz clock, synchronous active-high reset, APB register access.
*/
// Overview of operation
// - Flag A goes high whenever sample A exceeds the threshold.
// - Every raised flag stays high for at least the pulse count.
// - The channel B flag exists only on quad and dual variants.
// - Channel C over-range detection exists only on the quad variant.
// - Pin C carries the clock only with the PLL on and clock requested.
// - Config zero, PLL off or power-down puts flag C on pin C.
// - Code 1 gives a reference copy, 2 divide-by-2, 3 divide-by-4.
// - Pin C clock runs from reset, no register access, if pins allow.
package ors_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // variants and widths
   localparam int unsigned VARIANT_QUAD   = 0;
   localparam int unsigned VARIANT_DUAL   = 1;
   localparam int unsigned VARIANT_SINGLE = 2;
   localparam int unsigned SAMPLE_W       = 9;
   localparam int unsigned COUNT_W        = 8;
   localparam int unsigned NUM_CH         = 4;

   ////////////////////////////////////////////////////////////////////////////
   // register offsets (byte addresses)
   localparam logic [7:0] OFS_CTRL       = 8'h00;
   localparam logic [7:0] OFS_STATE      = 8'h04;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK   = 8'h0c;

   // control register fields
   localparam int unsigned CTRL_THR_LSB  = 0;
   localparam int unsigned CTRL_CNT_LSB  = 16;
   localparam int unsigned CTRL_OVR_EN   = 24;
   localparam int unsigned CTRL_OVR_LSB  = 25;

   // state register fields
   localparam int unsigned STATE_FLAG_LSB = 0;
   localparam int unsigned STATE_CLK_ACT  = 4;
   localparam int unsigned STATE_CFG_LSB  = 5;
   localparam int unsigned STATE_PLL_EN   = 7;
   localparam int unsigned STATE_PD       = 8;

   // interrupt bits: one per channel rise, one for pin C mode change
   localparam int unsigned IRQ_W          = 5;
   localparam int unsigned IRQ_MODE_BIT   = 4;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [SAMPLE_W-1:0] RST_THRESHOLD = 9'h1ff;
   localparam logic [COUNT_W-1:0]  RST_MIN_COUNT = 8'h01;
   localparam logic [1:0]          RST_OVR_CFG   = 2'h0;
   localparam logic [IRQ_W-1:0]    RST_IRQ_MASK  = 5'h00;

   ////////////////////////////////////////////////////////////////////////////
   // clock-out constants
   localparam logic [1:0] CFG_OFF  = 2'h0;
   localparam logic [1:0] CFG_COPY = 2'h1;
   localparam logic [1:0] CFG_DIV2 = 2'h2;
   localparam logic [1:0] CFG_DIV4 = 2'h3;
   // internal reference half period in clock cycles
   localparam logic [3:0] REF_HALF_CYC = 4'h2;
   localparam logic [2:0] PHASE_LAST   = 3'h7;

   typedef enum logic [1:0] {
      ORS_ST_FLAG  = 2'b00,
      ORS_ST_ARM   = 2'b01,
      ORS_ST_CLOCK = 2'b11
   } ors_pin_state_t;

endpackage : ors_pkg

// >>> ors_ovr_detect.sv
/*
 one channel of over-range detection with minimum pulse stretch.
 assumes samples on the same clock as the block, no synchroniser needed.
*/
`timescale 1ns/1ps
module ors_ovr_detect
   import ors_pkg::*;
(
   input  wire logic                clock,
   input  wire logic                rst,
   input  wire logic                enable,
   input  wire logic [SAMPLE_W-1:0] sample,
   input  wire logic [SAMPLE_W-1:0] threshold,
   input  wire logic [COUNT_W-1:0]  minCount,
   output logic                     flag
);

   logic [COUNT_W-1:0] cnt_reg;
   logic [COUNT_W-1:0] cnt_next;
   logic               flag_next;
   wire                over     = enable && (sample > threshold);
   // zero count still gives one full cycle
   wire [COUNT_W-1:0]  loadVal  = (minCount == '0) ? 8'h01 : minCount;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      cnt_next  = cnt_reg;
      flag_next = 1'b0;
      if (over) begin
         cnt_next  = loadVal;
         flag_next = 1'b1;
      end else if (cnt_reg > 8'h01) begin
         cnt_next  = cnt_reg - 8'h01;
         flag_next = 1'b1;
      end else begin
         cnt_next  = '0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         cnt_reg <= '0;
         flag    <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         flag    <= flag_next;
      end
   end

endmodule : ors_ovr_detect

// >>> ors_clk_out.sv
/*
 pin C driver: flag C or a reference clock copy, divide-by-2 or divide-by-4.
 assumes clockReq and cfgSel are already synchronised and stable.
*/
`timescale 1ns/1ps
module ors_clk_out
   import ors_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       clockReq,
   input  wire logic [1:0] cfgSel,
   input  wire logic       flagC,
   output logic            pinOut,
   output logic            clockActive,
   output logic [1:0]      activeCfg
);

   ors_pin_state_t state_reg;
   ors_pin_state_t state_next;
   logic [3:0]     div_reg;
   logic [2:0]     phase_reg;
   logic           waveSel;

   wire halfEn   = (div_reg == REF_HALF_CYC - 4'h1);
   // all three waves are low together only as the phase wraps to zero
   wire boundary = halfEn && (phase_reg == PHASE_LAST);

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock) begin
      if (rst || halfEn) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + 4'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         phase_reg <= '0;
      end else if (halfEn) begin
         phase_reg <= phase_reg + 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ORS_ST_FLAG: begin
            if (clockReq) begin
               state_next = ORS_ST_ARM;
            end
         end
         ORS_ST_ARM: begin
            if (!clockReq) begin
               state_next = ORS_ST_FLAG;
            end else if (boundary) begin
               state_next = ORS_ST_CLOCK;
            end
         end
         ORS_ST_CLOCK: begin
            if (!clockReq && boundary) begin
               state_next = ORS_ST_FLAG;
            end
         end
         default: state_next = ORS_ST_FLAG;
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg <= ORS_ST_FLAG;
      end else begin
         state_reg <= state_next;
      end
   end

   // ratio only changes at the wrap, so no runt edges
   always_ff @(posedge clock) begin
      if (rst) begin
         activeCfg <= CFG_OFF;
      end else if (boundary && clockReq) begin
         activeCfg <= cfgSel;
      end else if (state_next == ORS_ST_FLAG) begin
         activeCfg <= CFG_OFF;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      case (activeCfg)
         CFG_COPY: waveSel = phase_reg[0];
         CFG_DIV2: waveSel = phase_reg[1];
         CFG_DIV4: waveSel = phase_reg[2];
         default:  waveSel = 1'b0;
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         pinOut      <= 1'b0;
         clockActive <= 1'b0;
      end else begin
         pinOut      <= (state_reg == ORS_ST_CLOCK) ? waveSel
                                                    : flagC;
         clockActive <= (state_reg == ORS_ST_CLOCK);
      end
   end

endmodule : ors_clk_out

// >>> ors_top.sv
/*
 over-range status pins with optional reference clock on pin C, APB regs.
 assumes samples on clock; pll enable, power-down and config come from pins.
*/
`timescale 1ns/1ps
module ors_top
   import ors_pkg::*;
#(
   parameter int unsigned VARIANT = VARIANT_QUAD
)
(
   input  wire logic                clock,
   input  wire logic                rst,
   input  wire logic [7:0]          paddr,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic [SAMPLE_W-1:0] sampleA,
   input  wire logic [SAMPLE_W-1:0] sampleB,
   input  wire logic [SAMPLE_W-1:0] sampleC,
   input  wire logic [SAMPLE_W-1:0] sampleD,
   input  wire logic                pllEnablePin,
   input  wire logic                powerDownPin,
   input  wire logic [1:0]          clockOutputConfig,
   output logic                     overrangeFlagA,
   output logic                     overrangeFlagB,
   output logic                     overrangeFlagCOrClock,
   output logic                     irq
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: three stages, accept once stages two and three agree
   localparam int unsigned PIN_W = 4;

   logic [PIN_W-1:0] pinRaw;
   logic [PIN_W-1:0] sync1_reg;
   logic [PIN_W-1:0] sync2_reg;
   logic [PIN_W-1:0] sync3_reg;
   logic [PIN_W-1:0] pinStable_reg;

   assign pinRaw = {clockOutputConfig, powerDownPin, pllEnablePin};

   genvar p;
   generate
      for (p = 0; p < PIN_W; p = p + 1) begin : gSync
         always_ff @(posedge clock) begin
            if (rst) begin
               sync1_reg[p]     <= 1'b0;
               sync2_reg[p]     <= 1'b0;
               sync3_reg[p]     <= 1'b0;
               pinStable_reg[p] <= 1'b0;
            end else begin
               sync1_reg[p] <= pinRaw[p];
               sync2_reg[p] <= sync1_reg[p];
               sync3_reg[p] <= sync2_reg[p];
               if (sync2_reg[p] == sync3_reg[p]) begin
                  pinStable_reg[p] <= sync3_reg[p];
               end
            end
         end
      end
   endgenerate

   wire       pllEnable = pinStable_reg[0];
   wire       powerDown = pinStable_reg[1];
   wire [1:0] pinCfg    = pinStable_reg[3:2];

   ////////////////////////////////////////////////////////////////////////////
   // control register
   logic [SAMPLE_W-1:0] threshold_reg;
   logic [COUNT_W-1:0]  minCount_reg;
   logic                ovrEn_reg;
   logic [1:0]          ovrCfg_reg;
   logic [IRQ_W-1:0]    irqStatus_reg;
   logic [IRQ_W-1:0]    irqStatus_next;
   logic [IRQ_W-1:0]    irqMask_reg;

   ////////////////////////////////////////////////////////////////////////////
   // apb decode
   wire setupPhase = psel && !penable;
   wire writeEn    = psel && penable && pwrite;
   wire hitCtrl    = (paddr == OFS_CTRL);
   wire hitState   = (paddr == OFS_STATE);
   wire hitIrqSt   = (paddr == OFS_IRQ_STATUS);
   wire hitIrqMask = (paddr == OFS_IRQ_MASK);
   wire hitAny     = hitCtrl || hitState || hitIrqSt || hitIrqMask;
   // state register is read only; writing it is refused
   wire badAccess  = !hitAny || (pwrite && hitState);

   assign pready = 1'b1;

   always_ff @(posedge clock) begin
      if (rst) begin
         threshold_reg <= RST_THRESHOLD;
         minCount_reg  <= RST_MIN_COUNT;
         ovrEn_reg     <= 1'b0;
         ovrCfg_reg    <= RST_OVR_CFG;
         irqMask_reg   <= RST_IRQ_MASK;
      end else if (writeEn && !badAccess) begin
         if (hitCtrl) begin
            threshold_reg <= pwdata[CTRL_THR_LSB +: SAMPLE_W];
            minCount_reg  <= pwdata[CTRL_CNT_LSB +: COUNT_W];
            ovrEn_reg     <= pwdata[CTRL_OVR_EN];
            ovrCfg_reg    <= pwdata[CTRL_OVR_LSB +: 2];
         end
         if (hitIrqMask) begin
            irqMask_reg <= pwdata[IRQ_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // detectors, one per channel, gated by the variant
   logic [SAMPLE_W-1:0] sampleArr [NUM_CH];
   logic [NUM_CH-1:0]   chPresent;
   logic [NUM_CH-1:0]   flags;

   assign sampleArr[0] = sampleA;
   assign sampleArr[1] = sampleB;
   assign sampleArr[2] = sampleC;
   assign sampleArr[3] = sampleD;

   assign chPresent[0] = 1'b1;
   assign chPresent[1] = (VARIANT != VARIANT_SINGLE);
   assign chPresent[2] = (VARIANT == VARIANT_QUAD);
   // channel D is kept internal; its pin lies outside this block
   assign chPresent[3] = (VARIANT == VARIANT_QUAD);

   genvar c;
   generate
      for (c = 0; c < NUM_CH; c = c + 1) begin : gChan
         ors_ovr_detect uDet (
            .clock     (clock),
            .rst       (rst),
            .enable    (chPresent[c]),
            .sample    (sampleArr[c]),
            .threshold (threshold_reg),
            .minCount  (minCount_reg),
            .flag      (flags[c])
         );
      end
   endgenerate

   assign overrangeFlagA = flags[0];
   assign overrangeFlagB = flags[1];

   ////////////////////////////////////////////////////////////////////////////
   // pin C: override takes the place of the pins once enabled
   wire [1:0] effCfg   = ovrEn_reg ? ovrCfg_reg : pinCfg;
   // no clock while powered down or without the pll
   wire       clockReq = pllEnable && !powerDown
                         && (effCfg != CFG_OFF);
   logic       clockActive;
   logic [1:0] activeCfg;

   ors_clk_out uClk (
      .clock       (clock),
      .rst         (rst),
      .clockReq    (clockReq),
      .cfgSel      (effCfg),
      .flagC       (flags[2]),
      .pinOut      (overrangeFlagCOrClock),
      .clockActive (clockActive),
      .activeCfg   (activeCfg)
   );

   ////////////////////////////////////////////////////////////////////////////
   // interrupts: sticky, write one to clear, set beats clear
   logic [NUM_CH-1:0] flagsDly_reg;
   logic              clkActDly_reg;

   wire [NUM_CH-1:0] flagRise = flags & ~flagsDly_reg;
   wire              modeChg  = clockActive ^ clkActDly_reg;
   wire [IRQ_W-1:0]  irqSet   = {modeChg, flagRise};
   wire [IRQ_W-1:0]  irqClr   = (writeEn && hitIrqSt) ? pwdata[IRQ_W-1:0]
                                                      : '0;

   assign irqStatus_next = (irqStatus_reg & ~irqClr) | irqSet;

   always_ff @(posedge clock) begin
      if (rst) begin
         flagsDly_reg  <= '0;
         clkActDly_reg <= 1'b0;
         irqStatus_reg <= '0;
         irq           <= 1'b0;
      end else begin
         flagsDly_reg  <= flags;
         clkActDly_reg <= clockActive;
         irqStatus_reg <= irqStatus_next;
         irq           <= |(irqStatus_next & irqMask_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data captured in the setup cycle, valid through the access cycle
   logic [31:0] readMux;

   always_comb begin
      readMux = '0;
      if (hitCtrl) begin
         readMux[CTRL_THR_LSB +: SAMPLE_W] = threshold_reg;
         readMux[CTRL_CNT_LSB +: COUNT_W]  = minCount_reg;
         readMux[CTRL_OVR_EN]              = ovrEn_reg;
         readMux[CTRL_OVR_LSB +: 2]        = ovrCfg_reg;
      end else if (hitState) begin
         readMux[STATE_FLAG_LSB +: NUM_CH] = flags;
         readMux[STATE_CLK_ACT]            = clockActive;
         readMux[STATE_CFG_LSB +: 2]       = activeCfg;
         readMux[STATE_PLL_EN]             = pllEnable;
         readMux[STATE_PD]                 = powerDown;
      end else if (hitIrqSt) begin
         readMux[IRQ_W-1:0] = irqStatus_reg;
      end else if (hitIrqMask) begin
         readMux[IRQ_W-1:0] = irqMask_reg;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         prdata  <= '0;
         pslverr <= 1'b0;
      end else if (setupPhase) begin
         prdata  <= pwrite ? 32'h0000_0000 : readMux;
         pslverr <= badAccess;
      end
   end

endmodule : ors_top

// >>> ors_asserts.sv
/*
 checker for ors_top: flags, pin C gating, apb refusals, irq masking.
 assumes bind from the bench top; threshold and count snooped from apb.
*/
`timescale 1ns/1ps
module ors_asserts
   import ors_pkg::*;
#(
   parameter int unsigned VARIANT = VARIANT_QUAD
)
(
   input wire logic                clock,
   input wire logic                rst,
   input wire logic [7:0]          paddr,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [31:0]         pwdata,
   input wire logic                pslverr,
   input wire logic [SAMPLE_W-1:0] sampleA,
   input wire logic [SAMPLE_W-1:0] sampleB,
   input wire logic [SAMPLE_W-1:0] sampleC,
   input wire logic                pllEnablePin,
   input wire logic                powerDownPin,
   input wire logic                overrangeFlagA,
   input wire logic                overrangeFlagB,
   input wire logic                overrangeFlagCOrClock,
   input wire logic                irq
);
   logic [8:0] thrReg;
   logic [7:0] cntReg, hiLenReg, runCReg, offCntReg, cAgeReg;
   logic       pinPrevReg;
   wire        wrEn   = psel && penable && pwrite;
   wire        pinC   = overrangeFlagCOrClock;
   wire        mapped = paddr inside {OFS_CTRL, OFS_STATE,
                                      OFS_IRQ_STATUS, OFS_IRQ_MASK};
   // flag C pulses may legally be short; only judge pin C once they are over
   wire        cQuiet = {1'b0, cAgeReg} > ({1'b0, cntReg} + 9'h002);

   function automatic logic [7:0] sat(input logic [7:0] x);
      return x + {7'h00, x != 8'hff};
   endfunction : sat

   // counters saturate so long idle spans never wrap back to small values
   always_ff @(posedge clock) begin
      if (rst) begin
         thrReg     <= RST_THRESHOLD;
         cntReg     <= RST_MIN_COUNT;
         hiLenReg   <= 8'h00;
         runCReg    <= 8'hff;
         offCntReg  <= 8'h00;
         cAgeReg    <= 8'hff;
         pinPrevReg <= 1'b0;
      end else begin
         if (wrEn && paddr == OFS_CTRL) begin
            thrReg <= pwdata[8:0];
            cntReg <= pwdata[23:16];
         end
         hiLenReg   <= overrangeFlagA ? sat(hiLenReg) : 8'h00;
         pinPrevReg <= pinC;
         runCReg    <= (pinC != pinPrevReg) ? 8'h01 : sat(runCReg);
         offCntReg  <= (!pllEnablePin || powerDownPin) ? sat(offCntReg)
                                                       : 8'h00;
         cAgeReg    <= (sampleC > thrReg) ? 8'h00 : sat(cAgeReg);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   flag_a_rise_a:
   assert property (sampleA > thrReg |=> overrangeFlagA)
      else $error("flag A missed an over-range sample");
   flag_hold_a:
   assert property (!overrangeFlagA && hiLenReg != 8'h00 |->
                    hiLenReg >= cntReg)
      else $error("flag A pulse shorter than the count");
   flag_b_rise_a:
   assert property (VARIANT != VARIANT_SINGLE && sampleB > thrReg |=>
                    overrangeFlagB)
      else $error("flag B missed an over-range sample");
   flag_b_absent_a:
   assert property (VARIANT == VARIANT_SINGLE |-> !overrangeFlagB)
      else $error("flag B raised on single variant");
   flag_c_absent_a:
   assert property (VARIANT != VARIANT_QUAD && offCntReg >= 8'h28 |->
                    !pinC)
      else $error("pin C flag raised on non-quad variant");
   clock_gated_a:
   assert property (offCntReg >= 8'h28 && cQuiet |-> !pinC)
      else $error("pin C active while pll off or powered down");
   no_runt_a:
   assert property (pinC != pinPrevReg && cQuiet |-> runCReg >= 8'h02)
      else $error("pin C pulse shorter than half a reference period");
   unmapped_err_a:
   assert property (psel && penable && !mapped |-> pslverr)
      else $error("unmapped access not refused");
   state_wr_err_a:
   assert property (wrEn && paddr == OFS_STATE |-> pslverr)
      else $error("write to state register not refused");
   mask_off_a:
   assert property (wrEn && paddr == OFS_IRQ_MASK &&
                    pwdata[4:0] == 5'h00 |=> ##1 !irq)
      else $error("irq stays high with all sources masked");
endmodule : ors_asserts

// >>> ors_host_model.sv
/*
 host logic watching pin C: last high run length and rising edge count.
 assumes pin C is sampled on the block clock; it only listens.
*/
`timescale 1ns/1ps
module ors_host_model
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        pinC,
   output logic      [7:0]  lastHigh,
   output logic      [15:0] rises
);
   logic [7:0] runReg;
   logic       prevReg;

   always_ff @(posedge clock) begin
      if (rst) begin
         runReg   <= 8'h00;
         prevReg  <= 1'b0;
         lastHigh <= 8'h00;
         rises    <= 16'h0000;
      end else begin
         prevReg <= pinC;
         runReg  <= pinC ? runReg + 8'h01 : 8'h00;
         if (!pinC && prevReg) lastHigh <= runReg;
         if (pinC && !prevReg) rises <= rises + 16'h0001;
      end
   end
endmodule : ors_host_model

// >>> ors_tb_top.sv
/*
 bench for ors_top: quad and single instances sharing apb and samples.
 assumes an apb slave that answers; pins settle within tens of clocks.
*/
`timescale 1ns/1ps
module ors_tb_top
   import ors_pkg::*;
;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [8:0]  smp = 9'h000;
   logic        pllEn = 1'b1, pd = 1'b0;
   logic [1:0]  cfg = 2'h1;
   logic [31:0] prdata;
   logic        pready, pslverr, flagA, flagB, flagC, irq, flagB1, flagC1;
   logic [7:0]  lastHigh;
   logic [15:0] rises, r0;
   logic [8:0]  vt[3] = '{9'h101, 9'h101, 9'h100};
   int          nt[3] = '{1, 8, 3};
   int          et[3] = '{5, 12, 0};
   int          cnt[5];
   int          n_mismatch = 0, checks = 0;

   always #20 clock = ~clock;

   ors_top #(.VARIANT(VARIANT_QUAD)) dut (.clock(clock), .rst(rst),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sampleA(smp), .sampleB(smp), .sampleC(smp),
      .sampleD(smp), .pllEnablePin(pllEn), .powerDownPin(pd),
      .clockOutputConfig(cfg), .overrangeFlagA(flagA),
      .overrangeFlagB(flagB), .overrangeFlagCOrClock(flagC), .irq(irq));
   ors_top #(.VARIANT(VARIANT_SINGLE)) dut1 (.clock(clock), .rst(rst),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
      .sampleA(smp), .sampleB(smp), .sampleC(smp), .sampleD(smp),
      .pllEnablePin(pllEn), .powerDownPin(pd), .clockOutputConfig(cfg),
      .overrangeFlagA(), .overrangeFlagB(flagB1),
      .overrangeFlagCOrClock(flagC1), .irq());
   ors_host_model host (.clock(clock), .rst(rst), .pinC(flagC),
      .lastHigh(lastHigh), .rises(rises));

   ////////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         n_mismatch++;
      end
   endtask : chk

   task automatic wt(input int n);
      repeat (n) @(posedge clock);
   endtask : wt

   // no limit of its own on pready; the watchdog ends a dead wait
   task automatic apb(input logic [7:0] a, input logic w,
                      input logic [31:0] d, input logic [31:0] expD,
                      input logic expE);
      logic [31:0] r;
      logic        e;
      @(posedge clock);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (!w) chk(r, expD);
      chk({31'h0, e}, {31'h0, expE});
   endtask : apb

   task automatic quiet;
      wt(60);
      r0 = rises;
      wt(40);
      chk({16'h0, rises}, {16'h0, r0});
   endtask : quiet

   task automatic burst(input logic [8:0] v, input int n);
      cnt = '{0, 0, 0, 0, 0};
      @(posedge clock);
      smp <= v;
      for (int k = 1; k <= 40; k++) begin
         @(posedge clock);
         if (k == n) smp <= 9'h000;
         cnt[0] += (flagA === 1'b1);
         cnt[1] += (flagB === 1'b1);
         cnt[2] += (flagC === 1'b1);
         cnt[3] += (flagB1 === 1'b1);
         cnt[4] += (flagC1 === 1'b1);
      end
   endtask : burst

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      wt(16);
      rst <= 1'b0;
      for (int c = 1; c < 4; c++) begin
         cfg <= 2'(c);
         wt(80);
         chk({24'h0, lastHigh}, 32'h1 << c);
         apb(OFS_STATE, 1'b0, 0, 32'h90 | (32'(c) << 5), 1'b0);
      end
      $display("test clock ratios done");
      apb(OFS_CTRL, 1'b0, 0, 32'h0001_01ff, 1'b0);
      apb(OFS_IRQ_MASK, 1'b0, 0, 32'h0, 1'b0);
      apb(OFS_CTRL, 1'b1, 32'h0100_01ff, 0, 1'b0);
      quiet();
      apb(OFS_CTRL, 1'b1, 32'h0500_01ff, 0, 1'b0);
      wt(80);
      chk({24'h0, lastHigh}, 32'h4);
      pd <= 1'b1;
      quiet();
      pd <= 1'b0;
      pllEn <= 1'b0;
      quiet();
      $display("test clock gating done");
      pllEn <= 1'b1;
      cfg <= 2'h0;
      apb(OFS_CTRL, 1'b1, 32'h0005_0100, 0, 1'b0);
      wt(60);
      for (int k = 0; k < 3; k++) begin
         burst(vt[k], nt[k]);
         chk(cnt[0], et[k]);
         chk(cnt[1], et[k]);
         chk(cnt[2], et[k]);
         chk(cnt[3], 0);
         chk(cnt[4], 0);
      end
      $display("test flags done");
      apb(OFS_IRQ_STATUS, 1'b1, 32'h1f, 0, 1'b0);
      apb(OFS_IRQ_STATUS, 1'b0, 0, 32'h0, 1'b0);
      apb(OFS_IRQ_MASK, 1'b1, 32'h01, 0, 1'b0);
      burst(9'h101, 1);
      chk({31'h0, irq}, 32'h1);
      apb(OFS_IRQ_STATUS, 1'b0, 0, 32'h0f, 1'b0);
      apb(OFS_IRQ_STATUS, 1'b1, 32'h01, 0, 1'b0);
      wt(3);
      chk({31'h0, irq}, 32'h0);
      apb(OFS_IRQ_STATUS, 1'b0, 0, 32'h0e, 1'b0);
      apb(OFS_IRQ_MASK, 1'b1, 32'h02, 0, 1'b0);
      wt(3);
      chk({31'h0, irq}, 32'h1);
      apb(OFS_IRQ_MASK, 1'b1, 32'h00, 0, 1'b0);
      wt(3);
      chk({31'h0, irq}, 32'h0);
      $display("test irq done");
      apb(8'h10, 1'b0, 0, 32'h0, 1'b1);
      apb(OFS_STATE, 1'b1, 32'hffff_ffff, 0, 1'b1);
      apb(OFS_CTRL, 1'b0, 0, 32'h0005_0100, 1'b0);
      $display("test refusals done");
      close_out();
   end

   // about twenty times the expected run length
   initial begin
      wt(20000);
      n_mismatch++;
      close_out();
   end
endmodule : ors_tb_top

bind ors_top ors_asserts #(.VARIANT(VARIANT)) chk_u (.clock(clock),
   .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pwdata(pwdata), .pslverr(pslverr),
   .sampleA(sampleA), .sampleB(sampleB), .sampleC(sampleC),
   .pllEnablePin(pllEnablePin), .powerDownPin(powerDownPin),
   .overrangeFlagA(overrangeFlagA), .overrangeFlagB(overrangeFlagB),
   .overrangeFlagCOrClock(overrangeFlagCOrClock), .irq(irq));
